// file: verilog/scrf_map.svh
`ifndef SCRF_MAP_SVH
`define SCRF_MAP_SVH

// ----------------------------------------------------------------
// command byte layout
// ----------------------------------------------------------------
`define SCRF_CMD_RESET      8'h00
`define SCRF_CMD_GATE_BIT   7
`define SCRF_CMD_RSVD_BIT   6
`define SCRF_MODE_HI_BIT    5
`define SCRF_MODE_LO_BIT    4
`define SCRF_TGT_MSB        2
`define SCRF_TGT_LSB        0

// ----------------------------------------------------------------
// transfer mode codes
// ----------------------------------------------------------------
`define SCRF_MODE_WRITE     2'h0
`define SCRF_MODE_READ      2'h1
`define SCRF_MODE_CONT      2'h2
`define SCRF_MODE_STOP      2'h3
`define SCRF_STOP_BYTE      8'h30

// ----------------------------------------------------------------
// target codes
// ----------------------------------------------------------------
`define SCRF_TGT_CMD_STAT   3'h0
`define SCRF_TGT_DATA       3'h1
`define SCRF_TGT_MODE       3'h2
`define SCRF_TGT_DAC        3'h4

// ----------------------------------------------------------------
// counts, last bit index of each length
// ----------------------------------------------------------------
`define SCRF_CMD_LAST       5'h06
`define SCRF_LAST_8         5'h07
`define SCRF_LAST_16        5'h0f
`define SCRF_LAST_24        5'h17
`define SCRF_ONES_LIMIT     6'h20
`define SCRF_BYTE_LAST      3'h7

`endif

// file: verilog/scrf_pkg.sv
package scrf_pkg;

  // interface state
  typedef enum logic [1:0] {
    ST_WAIT,
    ST_CMD,
    ST_XFER,
    ST_CONT
  } scrf_state_t;

  // command register image
  typedef struct packed {
    logic gate;
    logic rsvd_hi;
    logic transfer_mode_hi;
    logic transfer_mode_lo;
    logic rsvd_lo;
    logic target_select_2;
    logic target_select_1;
    logic target_select_0;
  } scrf_cmd_t;

  // per-bit transfer report to the register file
  typedef struct packed {
    logic       active;
    logic       is_write;
    logic       bit_stb;
    logic       bit_val;
    logic       done;
    logic [4:0] bit_idx;
  } scrf_xfer_t;

endpackage

// file: verilog/scrf_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser, first stage read only by the second
module scrf_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;

  // ----------------------------------------------------------------
  // synchroniser stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else if (ce_i) begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// file: verilog/scrf_top.sv
`timescale 1ns/1ps
`include "scrf_map.svh"

module scrf_top (
  input  wire logic                 clk_sys_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 ce_i,
  input  wire logic                 sclk_i,
  input  wire logic                 din_i,
  input  wire logic                 word_len24_i,
  output scrf_pkg::scrf_cmd_t       cmd_o,
  output scrf_pkg::scrf_state_t     state_o,
  output scrf_pkg::scrf_xfer_t      xfer_o,
  output logic                      soft_reset_o
);
  import scrf_pkg::*;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  logic [1:0]  pins_s;
  logic        sclk_d;
  scrf_state_t state;
  scrf_cmd_t   cmd;
  logic [7:0]  shreg;
  logic [4:0]  cnt;
  logic [4:0]  len_last;
  logic [2:0]  phase;
  logic [5:0]  ones;
  logic        in_write;
  logic [2:0]  arm;

  // serial clock and data come from another party, so both resync
  scrf_sync #(
    .W         (2)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .async_i   ({din_i, sclk_i}),
    .sync_o    (pins_s)
  );

  wire sclk_s = pins_s[0];
  wire din_s  = pins_s[1];

  // rising serial edge is the sampling edge for data input; arm hides
  // the false rise while the synchroniser fills from its reset zero, so
  // a serial edge in the first three cycles after reset is lost
  // no false edge after reset
  wire sclk_rise = sclk_s & ~sclk_d & arm[2];

  // ----------------------------------------------------------------
  // recovery pattern
  // ----------------------------------------------------------------
  // ones run counter
  wire       ones_sat  = (ones == `SCRF_ONES_LIMIT);
  wire [5:0] ones_inc  = ones + 6'h01;
  wire [5:0] next_ones = !din_s ? 6'h00 : (ones_sat ? ones : ones_inc);
  // fire once on the 32nd one
  wire       pat_hit   = sclk_rise & din_s &
                         (ones_inc == `SCRF_ONES_LIMIT) & !ones_sat;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // msb first, so the new bit lands at the bottom
  wire [7:0] window   = {shreg[6:0], din_s};
  // gate bit was zero, next seven bits load
  wire [7:0] cmd_word = {1'b0, shreg[5:0], din_s};
  wire [1:0] new_mode = cmd_word[`SCRF_MODE_HI_BIT:`SCRF_MODE_LO_BIT];
  wire [2:0] new_tgt  = cmd_word[`SCRF_TGT_MSB:`SCRF_TGT_LSB];
  // stop byte seen in the shift window
  wire       stop_seen = (window == `SCRF_STOP_BYTE);
  // byte boundary measured from continuous-read entry
  wire       byte_end  = (phase == `SCRF_BYTE_LAST);
  wire       xfer_end  = (cnt == len_last);
  wire [4:0] cnt_inc   = cnt + 5'h01;
  wire [2:0] phase_inc = phase + 3'h1;

  // data register length follows the word length setting
  wire [4:0] data_last = word_len24_i ? `SCRF_LAST_24 : `SCRF_LAST_16;
  // length per target, 8 for command/status and dac
  wire [4:0] tgt_last  =
    (new_tgt == `SCRF_TGT_CMD_STAT) ? `SCRF_LAST_8  :
    (new_tgt == `SCRF_TGT_DATA)     ? data_last     :
    (new_tgt == `SCRF_TGT_MODE)     ? `SCRF_LAST_16 :
    (new_tgt == `SCRF_TGT_DAC)      ? `SCRF_LAST_8  : `SCRF_LAST_24;

  // ----------------------------------------------------------------
  // interface state machine
  // ----------------------------------------------------------------
  scrf_state_t next_state;
  scrf_cmd_t   next_cmd;
  logic [4:0]  next_cnt;
  logic [4:0]  next_len;
  logic [2:0]  next_phase;
  logic        next_write;
  logic        bit_in_xfer;
  logic        xfer_done;

  // next state evaluated per serial edge; applied only on sclk_rise
  always_comb begin
    next_state  = state;
    next_cmd    = cmd;
    next_cnt    = cnt;
    next_len    = len_last;
    next_phase  = phase;
    next_write  = in_write;
    bit_in_xfer = 1'b0;
    xfer_done   = 1'b0;
    case (state)
      ST_WAIT: begin
        // gate bit one keeps us here
        if (!din_s) begin
          next_state = ST_CMD;
          next_cnt   = 5'h00;
        end
      end
      ST_CMD: begin
        if (cnt == `SCRF_CMD_LAST) begin
          next_cmd = scrf_cmd_t'(cmd_word);
          next_cnt = 5'h00;
          next_len = tgt_last;
          case (new_mode)
            `SCRF_MODE_WRITE: begin
              next_state = ST_XFER;
              next_write = 1'b1;
            end
            `SCRF_MODE_READ: begin
              next_state = ST_XFER;
              next_write = 1'b0;
            end
            `SCRF_MODE_CONT: begin
              next_state = ST_CONT;
              next_write = 1'b0;
              next_phase = 3'h0;
            end
            default: begin
              // stop code outside continuous read has nothing to stop
              next_state = ST_WAIT;
            end
          endcase
        end else begin
          next_cnt = cnt_inc;
        end
      end
      ST_XFER: begin
        bit_in_xfer = 1'b1;
        if (xfer_end) begin
          // single shot finished, back to command wait
          xfer_done  = 1'b1;
          next_state = ST_WAIT;
          next_cnt   = 5'h00;
        end else begin
          next_cnt = cnt_inc;
        end
      end
      ST_CONT: begin
        // every serial edge is watched in continuous read
        bit_in_xfer = 1'b1;
        next_phase  = phase_inc;
        if (xfer_end) begin
          // re-arm the same read with no command byte
          xfer_done = 1'b1;
          next_cnt  = 5'h00;
        end else begin
          next_cnt = cnt_inc;
        end
        // leave only on the stop byte
        // stop code 11 with low nibble zero
        if (byte_end && stop_seen) begin
          next_state = ST_WAIT;
          next_cnt   = 5'h00;
        end
      end
      default: begin
        next_state = ST_WAIT;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // reset lands in the command wait state
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_d <= 1'b0;
      arm    <= 3'h0;
      ones   <= 6'h00;
      shreg  <= 8'h00;
    end else if (ce_i) begin
      sclk_d <= sclk_s;
      arm    <= {arm[1:0], 1'b1};
      if (sclk_rise) begin
        ones  <= next_ones;
        shreg <= window;
      end
    end
  end

  // recovery overrides whatever the machine was doing
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state    <= ST_WAIT;
      cmd      <= scrf_cmd_t'(`SCRF_CMD_RESET);
      cnt      <= 5'h00;
      len_last <= `SCRF_LAST_8;
      phase    <= 3'h0;
      in_write <= 1'b0;
    end else if (ce_i && pat_hit) begin
      state    <= ST_WAIT;
      cmd      <= scrf_cmd_t'(`SCRF_CMD_RESET);
      cnt      <= 5'h00;
      len_last <= `SCRF_LAST_8;
      phase    <= 3'h0;
      in_write <= 1'b0;
    end else if (ce_i && sclk_rise) begin
      state    <= next_state;
      cmd      <= next_cmd;
      cnt      <= next_cnt;
      len_last <= next_len;
      phase    <= next_phase;
      in_write <= next_write;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // pulses last one system cycle, one cycle after the serial edge
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      xfer_o       <= '0;
      soft_reset_o <= 1'b0;
      cmd_o        <= scrf_cmd_t'(`SCRF_CMD_RESET);
      state_o      <= ST_WAIT;
    end else if (ce_i) begin
      soft_reset_o     <= pat_hit;
      cmd_o            <= cmd;
      state_o          <= state;
      xfer_o.active    <= (state == ST_XFER) || (state == ST_CONT);
      xfer_o.is_write  <= in_write;
      xfer_o.bit_stb   <= sclk_rise & bit_in_xfer & !pat_hit;
      xfer_o.done      <= sclk_rise & xfer_done & !pat_hit;
      if (sclk_rise) begin
        xfer_o.bit_val <= din_s;
        xfer_o.bit_idx <= cnt;
      end
    end
  end

endmodule

// file: verification/scrf_host.sv
`timescale 1ns/1ps

// host serial master; clock idles high and stands still between frames
module scrf_host (
  input  wire logic clk_sys_i,
  output logic      sclk_o,
  output logic      din_o
);
  initial begin
    sclk_o = 1'b1;
    din_o  = 1'b0;
  end

  // ----------------------------------------------------------------
  // frame driver, 8 system clocks per serial bit
  // ----------------------------------------------------------------
  // msb first
  task automatic send(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clk_sys_i);
      sclk_o = 1'b0;
      din_o  = v[i];
      repeat (4) @(negedge clk_sys_i);
      sclk_o = 1'b1;
      repeat (3) @(negedge clk_sys_i);
    end
    // released line flips so stale data is never mistaken for valid
    din_o = ~din_o;
  endtask
endmodule

// file: verification/scrf_top_props.sv
`timescale 1ns/1ps

module scrf_top_props (
  input wire logic           clk_sys_i,
  input wire logic           sys_rst_i,
  input wire logic           ce_i,
  input wire logic           sclk_i,
  input wire logic           din_i,
  input wire logic           word_len24_i,
  input scrf_pkg::scrf_cmd_t   cmd_o,
  input scrf_pkg::scrf_state_t state_o,
  input scrf_pkg::scrf_xfer_t  xfer_o,
  input wire logic           soft_reset_o
);
  import scrf_pkg::*;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // recovery pulse: one cycle, then gone
  sequence s_pulse;
    soft_reset_o ##1 !soft_reset_o;
  endsequence

  // leaving continuous read: state_o lags, so the cause is a cycle back
  sequence s_cont_exit;
    state_o == ST_CONT ##1 state_o != ST_CONT;
  endsequence

  property p_rst_wait;
    $fell(sys_rst_i) |-> state_o == ST_WAIT && cmd_o == 8'h00;
  endproperty
  property p_gate_zero;
    cmd_o.gate == 1'b0;
  endproperty
  property p_wait_next;
    state_o == ST_WAIT |=> state_o inside {ST_WAIT, ST_CMD};
  endproperty
  property p_done_state;
    xfer_o.done |-> xfer_o.bit_stb ##1 state_o inside {ST_WAIT, ST_CONT};
  endproperty
  property p_done_len;
    xfer_o.done |-> xfer_o.bit_idx inside {5'h07, 5'h0f, 5'h17};
  endproperty
  property p_stb_pulse;
    xfer_o.bit_stb |=> !xfer_o.bit_stb;
  endproperty
  property p_soft_pulse;
    soft_reset_o |-> s_pulse;
  endproperty
  property p_soft_state;
    soft_reset_o |=> state_o == ST_WAIT && cmd_o == 8'h00;
  endproperty
  property p_cont_exit;
    s_cont_exit |-> $past(soft_reset_o) || ($past(xfer_o.bit_stb) &&
      $past(xfer_o.bit_idx[2:0]) == 3'h7 && $past(xfer_o.bit_val) == 1'b0);
  endproperty

  a_rst_wait:   assert property (p_rst_wait)
    else $error("state not idle after reset");
  a_gate_zero:  assert property (p_gate_zero)
    else $error("gate bit stored as one");
  a_wait_next:  assert property (p_wait_next)
    else $error("left idle without a command byte");
  a_done_state: assert property (p_done_state)
    else $error("wrong state at end of transfer");
  a_done_len:   assert property (p_done_len)
    else $error("transfer length off");
  a_stb_pulse:  assert property (p_stb_pulse)
    else $error("bit strobe longer than a cycle");
  a_soft_pulse: assert property (p_soft_pulse)
    else $error("recovery pulse longer than a cycle");
  a_soft_state: assert property (p_soft_state)
    else $error("recovery did not clear state");
  a_cont_exit:  assert property (p_cont_exit)
    else $error("continuous read left off a byte boundary");
endmodule

bind scrf_top scrf_top_props i_props (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
  .sclk_i(sclk_i), .din_i(din_i), .word_len24_i(word_len24_i),
  .cmd_o(cmd_o), .state_o(state_o), .xfer_o(xfer_o),
  .soft_reset_o(soft_reset_o)
);

// file: verification/tb_scrf_top.sv
`timescale 1ns/1ps

module tb_scrf_top;
  import scrf_pkg::*;

  logic        clk_sys_i    = 1'b0;
  logic        sys_rst_i    = 1'b1;
  logic        word_len24_i = 1'b0;
  logic        sclk;
  logic        din;
  scrf_cmd_t   cmd_o;
  scrf_state_t state_o;
  scrf_xfer_t  xfer_o;
  logic        soft_reset_o;
  int          n_fail = 0;
  int          checks = 0;
  int          n_done = 0;
  int          n_soft = 0;
  int          cyc    = 0;

  always #25 clk_sys_i = ~clk_sys_i;

  scrf_host i_host (.clk_sys_i(clk_sys_i), .sclk_o(sclk), .din_o(din));

  scrf_top i_dut (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .ce_i        (1'b1),
    .sclk_i      (sclk),
    .din_i       (din),
    .word_len24_i(word_len24_i),
    .cmd_o       (cmd_o),
    .state_o     (state_o),
    .xfer_o      (xfer_o),
    .soft_reset_o(soft_reset_o)
  );

  // pulse counters and a hang limit well above the ~3000 cycles needed
  always @(negedge clk_sys_i) begin
    cyc++;
    if (xfer_o.done === 1'b1) n_done++;
    if (soft_reset_o === 1'b1) n_soft++;
    if (cyc == 8000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // send bits, then let the synchroniser latency drain
  task automatic snd(input logic [31:0] v, input int n);
    i_host.send(v, n);
    repeat (5) @(negedge clk_sys_i);
  endtask

  function automatic int xlen(input logic [2:0] t, input logic wl);
    case (t)
      3'h0, 3'h4: return 8;
      3'h1: return wl ? 24 : 16;
      3'h2: return 16;
      default: return 24;
    endcase
  endfunction

  task automatic t_reset;
    check(state_o, ST_WAIT);
    check(cmd_o, 8'h00);
    snd(32'h7, 3);
    check(state_o, ST_WAIT);
  endtask

  // every target, reads and writes alternating, both word lengths
  task automatic t_regs;
    logic [2:0] t;
    logic [7:0] c;
    int         n;
    for (int i = 0; i < 9; i++) begin
      t = (i == 8) ? 3'h1 : i[2:0];
      word_len24_i = (i == 8);
      c = {3'b000, i[0], 1'b0, t};
      n = xlen(t, word_len24_i);
      n_done = 0;
      snd({22'h0, 2'b11, c}, 10);
      check(cmd_o, c);
      check(state_o, ST_XFER);
      check(xfer_o.is_write, !i[0]);
      check(xfer_o.active, 1'b1);
      snd(32'h0, n - 1);
      check(state_o, ST_XFER);
      snd(32'h1, 1);
      check(state_o, ST_WAIT);
      check(xfer_o.active, 1'b0);
      check(n_done, 1);
      check(xfer_o.bit_idx, n - 1);
      check(xfer_o.bit_val, 1'b1);
    end
  endtask

  task automatic t_cont;
    word_len24_i = 1'b0;
    snd(32'h21, 8);
    check(state_o, ST_CONT);
    n_done = 0;
    snd(32'h0, 16);
    check(n_done, 1);
    snd(32'h0300, 16);
    check(state_o, ST_CONT);
    snd(32'h31, 8);
    check(state_o, ST_CONT);
    snd(32'h30, 8);
    check(state_o, ST_WAIT);
    snd(32'h30, 8);
    check(state_o, ST_WAIT);
    check(cmd_o, 8'h30);
  endtask

  task automatic t_recover;
    snd(32'h12, 8);
    n_soft = 0;
    snd(32'h0, 3);
    snd(32'h7fff_ffff, 31);
    check(n_soft, 0);
    snd(32'h1, 1);
    check(n_soft, 1);
    check(cmd_o, 8'h00);
    snd(32'h1, 1);
    check(n_soft, 1);
    check(state_o, ST_WAIT);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    t_reset();
    t_regs();
    t_cont();
    t_recover();
    summarize();
  end
endmodule
